/* bis_pkg.sv */
/*
 * Constants for the I/O window top register and the secondary bus
 * status register of the bridge configuration header.
 * Assumes dword-wide configuration accesses with byte enables.
 */
package bis_pkg;
   // Byte offsets in configuration space
   localparam logic [7:0] IO_TOP_OFF = 8'h1D;
   localparam logic [7:0] SEC_STATUS_OFF = 8'h1E;
   localparam logic [7:0] IO_TOP_UPPER_OFF = 8'h32;
   localparam logic [7:0] BRIDGE_CTRL_OFF = 8'h3E;
   // Dword holding both registers, and byte lanes inside it
   localparam logic [5:0] DW_IO_STATUS = 6'h07;
   localparam int LANE_IO_TOP = 1;
   localparam int LANE_STATUS_HI = 3;
   // io_window_top fields
   localparam logic [7:0] IO_TOP_RESET = 8'h01;
   localparam logic [3:0] IO_ADDRESSING_WIDTH = 4'h1;
   localparam logic [11:0] IO_TOP_LOW_ONES = 12'hFFF;
   // secondary_bus_status bit positions
   localparam int ST_DETECTED_PARITY = 15;
   localparam int ST_RECEIVED_SYSTEM = 14;
   localparam int ST_RECEIVED_MASTER = 13;
   localparam int ST_RECEIVED_TARGET = 12;
   localparam int ST_SIGNALED_TARGET = 11;
   localparam int ST_DEVSEL_LO = 9;
   localparam int ST_MASTER_DATA_PARITY = 8;
   localparam int ST_BACK_TO_BACK = 7;
   localparam int ST_HIGH_SPEED = 5;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic [15:0] STATUS_RESET = 16'h0280;
   localparam int NUM_EVENTS = 6;
endpackage

/* bis_sticky_bit.sv */
/*
 * One sticky event flag, cleared by software writing one.
 * Assumes set and clear are single-cycle qualified strobes.
 */
`timescale 1ns/1ns
module bis_sticky_bit (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic q_o
);
   logic flag_r;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_r <= 1'b0;
      end else if (set_i) begin
         flag_r <= 1'b1;
      end else if (clr_i) begin
         flag_r <= 1'b0;
      end
   end

   assign q_o = flag_r;
endmodule

/* bis_io_window.sv */
/*
 * Registered inclusive range check of an I/O address against base and top.
 * Assumes base and top are stable while a check is in flight.
 */
`timescale 1ns/1ns
module bis_io_window (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic check_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] base_i,
   input wire logic [31:0] top_i,
   output logic done_o,
   output logic hit_o
);
   logic done_r;
   logic hit_r;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
         hit_r <= 1'b0;
      end else begin
         done_r <= check_i;
         if (check_i) begin
            hit_r <= (addr_i >= base_i) && (addr_i <= top_i);
         end
      end
   end

   assign done_o = done_r;
   assign hit_o = hit_r;
endmodule

/* bis_io_status_regs.sv */
/*
 * I/O window top register and secondary bus status register, with the
 * I/O forwarding window check that uses the programmed top.
 * Assumes event inputs are one-cycle pulses from the secondary bus
 * interface, synchronous to core_clk_i, and that the upper-16-bit top,
 * the window base and the parity response enable come from their own
 * registers elsewhere in the header.
 */
// Functional notes
// - The top nibble of the window top register gives address bits 15:12 and bits 11:0 are all ones.
// - The programmed top decides whether an I/O transaction lies inside the forwarded window.
// - Address bits 31:16 of the top come from the separate upper-16-bit limit register at 32h.
// - The low nibble of the window top register is read-only 1h for 32-bit I/O addressing.
// - Bit 15 sets on an address or attribute error as potential target or a data error as write target or read master.
// - Bit 15 sets regardless of the parity response enable.
// - Bit 14 sets whenever SERR is seen asserted on the secondary bus.
// - Bit 13 sets when a transaction the bridge masters ends in master abort.
// - Bit 12 sets when the secondary interface receives a target abort.
// - Bit 11 sets when the bridge as target ends a transaction with target abort.
// - Bits 10:9 are read-only 01b for medium DEVSEL decoding.
// - Bit 8 sets only as bus master with parity response enabled and PERR driven on a read or seen on a write.
// - Bit 7 is read-only one for fast back-to-back support.
// - Bit 5 is read-only and shows the current level of the 66 MHz enable pin.
// - Bit 6 and bits 4:0 are reserved and read zero.
// - Event bits hold until software clears them and the rest are read-only.
`timescale 1ns/1ns
module bis_io_status_regs (
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Configuration access, dword address with byte enables
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [5:0] cfg_dw_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Companion header fields
   input wire logic [15:0] io_top_upper_i,
   input wire logic [31:0] io_window_base_i,
   input wire logic parity_response_enable_i,
   input wire logic high_speed_enable_pin_i,
   // Secondary bus events
   input wire logic addr_attr_err_target_i,
   input wire logic data_err_write_target_i,
   input wire logic data_err_read_master_i,
   input wire logic serr_seen_i,
   input wire logic master_abort_i,
   input wire logic target_abort_rcvd_i,
   input wire logic target_abort_sent_i,
   input wire logic bus_master_i,
   input wire logic perr_driven_read_i,
   input wire logic perr_seen_write_i,
   // Forwarding check
   input wire logic io_check_i,
   input wire logic [31:0] io_addr_i,
   output logic io_check_done_o,
   output logic io_in_window_o,
   output logic [31:0] io_range_top_o
);
   logic [3:0] io_range_top_r;
   logic [31:0] cfg_rdata_r;
   logic cfg_rvalid_r;
   logic [31:0] io_range_top_r32;
   logic [15:0] status_word;
   logic [bis_pkg::NUM_EVENTS-1:0] ev_set;
   logic [bis_pkg::NUM_EVENTS-1:0] ev_clr;
   logic [bis_pkg::NUM_EVENTS-1:0] ev_q;
   logic status_hi_wr;
   logic io_top_wr;

   // Write strobe for one byte lane of the shared dword
   function automatic logic lane_write(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                                       input int lane);
      lane_write = wr && (dw == bis_pkg::DW_IO_STATUS) && be[lane];
   endfunction

   assign io_top_wr = lane_write(cfg_wr_i, cfg_dw_i, cfg_be_i, bis_pkg::LANE_IO_TOP);
   assign status_hi_wr = lane_write(cfg_wr_i, cfg_dw_i, cfg_be_i, bis_pkg::LANE_STATUS_HI);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_range_top_r <= bis_pkg::IO_TOP_RESET[7:4];
      end else if (io_top_wr) begin
         io_range_top_r <= cfg_wdata_i[15:12];
      end
   end

   assign io_range_top_r32 = {io_top_upper_i, io_range_top_r, bis_pkg::IO_TOP_LOW_ONES};
   assign io_range_top_o = io_range_top_r32;

   // Event set terms, index order 15,14,13,12,11,8
   // three parity detection cases
   assign ev_set[5] = addr_attr_err_target_i | data_err_write_target_i | data_err_read_master_i;
   assign ev_set[4] = serr_seen_i;
   assign ev_set[3] = master_abort_i;
   assign ev_set[2] = target_abort_rcvd_i;
   assign ev_set[1] = target_abort_sent_i;
   assign ev_set[0] = bus_master_i & parity_response_enable_i & (perr_driven_read_i | perr_seen_write_i);

   // write one clears, upper status byte
   assign ev_clr[5] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_DETECTED_PARITY];
   assign ev_clr[4] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_RECEIVED_SYSTEM];
   assign ev_clr[3] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_RECEIVED_MASTER];
   assign ev_clr[2] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_RECEIVED_TARGET];
   assign ev_clr[1] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_SIGNALED_TARGET];
   assign ev_clr[0] = status_hi_wr & cfg_wdata_i[16 + bis_pkg::ST_MASTER_DATA_PARITY];

   genvar gi;
   generate
      for (gi = 0; gi < bis_pkg::NUM_EVENTS; gi++) begin : g_ev
         bis_sticky_bit u_flag (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .set_i(ev_set[gi]),
            .clr_i(ev_clr[gi]),
            .q_o(ev_q[gi])
         );
      end
   endgenerate

   always_comb begin
      status_word = 16'h0000;
      status_word[bis_pkg::ST_DETECTED_PARITY] = ev_q[5];
      status_word[bis_pkg::ST_RECEIVED_SYSTEM] = ev_q[4];
      status_word[bis_pkg::ST_RECEIVED_MASTER] = ev_q[3];
      status_word[bis_pkg::ST_RECEIVED_TARGET] = ev_q[2];
      status_word[bis_pkg::ST_SIGNALED_TARGET] = ev_q[1];
      status_word[bis_pkg::ST_DEVSEL_LO +: 2] = bis_pkg::DEVSEL_MEDIUM;
      status_word[bis_pkg::ST_MASTER_DATA_PARITY] = ev_q[0];
      status_word[bis_pkg::ST_BACK_TO_BACK] = 1'b1;
      status_word[bis_pkg::ST_HIGH_SPEED] = high_speed_enable_pin_i;
      // bit 6 and 4:0 stay zero
   end

   // Read data registered; other dwords of the header live elsewhere, read zero here
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_rdata_r <= 32'h0000_0000;
      end else if (cfg_rd_i) begin
         if (cfg_dw_i == bis_pkg::DW_IO_STATUS) begin
            cfg_rdata_r <= {status_word, io_range_top_r, bis_pkg::IO_ADDRESSING_WIDTH, 8'h00};
         end else begin
            cfg_rdata_r <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_rvalid_r <= 1'b0;
      end else begin
         cfg_rvalid_r <= cfg_rd_i;
      end
   end

   assign cfg_rdata_o = cfg_rdata_r;
   assign cfg_rvalid_o = cfg_rvalid_r;

   bis_io_window u_window (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .check_i(io_check_i),
      .addr_i(io_addr_i),
      .base_i(io_window_base_i),
      .top_i(io_range_top_r32),
      .done_o(io_check_done_o),
      .hit_o(io_in_window_o)
   );

   // Assertions
   sequence s_status_read;
      cfg_rd_i && cfg_dw_i == bis_pkg::DW_IO_STATUS;
   endsequence

   sequence s_answer;
      cfg_rvalid_o;
   endsequence

   sequence s_check_below;
      io_check_i && io_addr_i < io_window_base_i;
   endsequence

   sequence s_check_above;
      io_check_i && io_addr_i > io_range_top_o;
   endsequence

   a_top_write_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      io_top_wr |=> io_range_top_o[15:12] == $past(cfg_wdata_i[15:12]) && io_range_top_o[11:0] == 12'hFFF)
      else $error("window top nibble not taken from write");

   a_top_upper_half: assert property (@(posedge core_clk_i) disable iff (rst_i)
      io_range_top_o[31:16] == io_top_upper_i)
      else $error("window top upper half mismatch");

   a_window_decision: assert property (@(posedge core_clk_i) disable iff (rst_i)
      io_check_i |=> io_check_done_o &&
         io_in_window_o == ($past(io_addr_i) >= $past(io_window_base_i) && $past(io_addr_i) <= $past(io_range_top_o)))
      else $error("window decision wrong");

   a_read_fixed_bits: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_status_read ##1 s_answer |-> cfg_rdata_o[11:8] == 4'h1 && cfg_rdata_o[26:25] == 2'b01 &&
         cfg_rdata_o[23] && !cfg_rdata_o[22] && cfg_rdata_o[20:16] == 5'h00)
      else $error("read-only status fields wrong");

   a_pin_reflected: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_status_read |=> cfg_rdata_o[21] == $past(high_speed_enable_pin_i))
      else $error("high speed bit does not follow pin");

   a_parity_ungated: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (data_err_write_target_i && !parity_response_enable_i) |=> status_word[15])
      else $error("detected parity not set without enable");

   a_serr_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      serr_seen_i |=> status_word[14] [*2])
      else $error("system fault bit not set or not held");

   a_received_master_termination_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      master_abort_i |=> status_word[13])
      else $error("master termination bit not set");

   a_tabort_rcvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
      target_abort_rcvd_i |=> status_word[12])
      else $error("received target termination bit not set");

   a_tabort_sent: assert property (@(posedge core_clk_i) disable iff (rst_i)
      target_abort_sent_i |=> status_word[11])
      else $error("signaled target termination bit not set");

   a_dpar_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!parity_response_enable_i || !bus_master_i) && !status_word[8] |=> !status_word[8])
      else $error("master data parity set without its conditions");

   a_sticky_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      status_word[15] && !(status_hi_wr && cfg_wdata_i[31]) |=> status_word[15])
      else $error("event bit lost without a clear");

   a_clear_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
      status_hi_wr && cfg_wdata_i[30] && !serr_seen_i |=> !status_word[14])
      else $error("write of one did not clear");

   a_set_wins: assert property (@(posedge core_clk_i) disable iff (rst_i)
      status_hi_wr && cfg_wdata_i[29] && master_abort_i |=> status_word[13])
      else $error("clear beat a same-cycle event");

   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !status_word[6] && status_word[4:0] == 5'h00 && status_word[7] && status_word[10:9] == 2'b01)
      else $error("reserved or fixed status bits wrong");

   // Read port: answer one cycle later, data held until the next read
   a_read_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cfg_rd_i |=> cfg_rvalid_o)
      else $error("read not answered next cycle");

   a_read_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !cfg_rd_i |=> !cfg_rvalid_o)
      else $error("read valid without a read");

   a_read_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !cfg_rd_i |=> $stable(cfg_rdata_o))
      else $error("read data changed without a read");

   a_other_dword: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cfg_rd_i && cfg_dw_i != bis_pkg::DW_IO_STATUS |=> cfg_rdata_o == 32'h0000_0000)
      else $error("unmapped dword read not zero");

   a_read_low_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_status_read |=> cfg_rdata_o[7:0] == 8'h00)
      else $error("base byte lane not zero");

   a_read_nibble: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_status_read |=> cfg_rdata_o[15:12] == $past(io_range_top_r))
      else $error("read nibble differs from window top");

   a_read_events: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_status_read |=> {cfg_rdata_o[31:27], cfg_rdata_o[24]} == $past(ev_q))
      else $error("read event bits differ from flags");

   a_top_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !io_top_wr |=> $stable(io_range_top_r))
      else $error("window top nibble changed without a write");

   // Each parity case sets bit 15 on its own, and the master data parity terms set bit 8
   a_addr_attr_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_attr_err_target_i |=> status_word[15])
      else $error("address or attribute error did not set bit 15");

   a_write_target_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      data_err_write_target_i |=> status_word[15])
      else $error("write target data error did not set bit 15");

   a_read_master_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      data_err_read_master_i |=> status_word[15])
      else $error("read master data error did not set bit 15");

   a_dpar_sets: assert property (@(posedge core_clk_i) disable iff (rst_i)
      bus_master_i && parity_response_enable_i && (perr_driven_read_i || perr_seen_write_i) |=> status_word[8])
      else $error("master data parity not set with its conditions");

   // A flag moves only through its own set or clear term
   a_no_spurious_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ev_set == 6'h00 |=> (ev_q & ~$past(ev_q)) == 6'h00)
      else $error("event bit set without an event");

   a_no_silent_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ev_clr == 6'h00 |=> (~ev_q & $past(ev_q)) == 6'h00)
      else $error("event bit cleared without a clear");

   a_zero_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
      status_hi_wr && !cfg_wdata_i[30] && status_word[14] |=> status_word[14])
      else $error("write of zero cleared an event bit");

   a_clear_needs_lane: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cfg_wr_i && !cfg_be_i[3] |=> (~ev_q & $past(ev_q)) == 6'h00)
      else $error("event bit cleared without upper lane");

   a_done_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !io_check_i |=> !io_check_done_o)
      else $error("check done without a request");

   a_hit_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !io_check_i |=> $stable(io_in_window_o))
      else $error("window decision changed without a check");

   a_below_base: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_check_below |=> !io_in_window_o)
      else $error("address below base forwarded");

   a_above_top: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_check_above |=> !io_in_window_o)
      else $error("address above top forwarded");
endmodule

/* bis_pci_agents.sv */
/*
 * Behavioural stand-in for the agents on the secondary PCI bus.
 * Assumes the bench calls pulse() from one process at a time.
 */
`timescale 1ns/1ns
module bis_pci_agents (
   input wire logic core_clk_i,
   output logic addr_attr_err_target_o,
   output logic data_err_write_target_o,
   output logic data_err_read_master_o,
   output logic serr_seen_o,
   output logic master_abort_o,
   output logic target_abort_rcvd_o,
   output logic target_abort_sent_o,
   output logic perr_driven_read_o,
   output logic perr_seen_write_o
);
   logic [8:0] ev_r = 9'h000;
   assign {perr_seen_write_o, perr_driven_read_o, target_abort_sent_o, target_abort_rcvd_o, master_abort_o,
           serr_seen_o, data_err_read_master_o, data_err_write_target_o, addr_attr_err_target_o} = ev_r;
   // Bus events are seen by the bridge for one clock only
   task automatic pulse(input int idx);
      @(posedge core_clk_i);
      ev_r <= 9'h001 << idx;
      @(posedge core_clk_i);
      ev_r <= 9'h000;
   endtask
endmodule

/* test_bridge_io_limit_secondary_status.sv */
/*
 * Self-checking bench for the I/O window top and secondary status registers.
 * Assumes the bus agent model drives the event pulses.
 */
`timescale 1ns/1ns
module test_bridge_io_limit_secondary_status;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [5:0] cfg_dw_i = 6'h00;
   logic [3:0] cfg_be_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h0;
   logic [31:0] cfg_rdata_o;
   logic cfg_rvalid_o;
   logic [15:0] io_top_upper_i = 16'h0;
   logic [31:0] io_window_base_i = 32'h0;
   logic parity_response_enable_i = 1'b0;
   logic high_speed_enable_pin_i = 1'b0;
   logic bus_master_i = 1'b0;
   logic io_check_i = 1'b0;
   logic [31:0] io_addr_i = 32'h0;
   logic io_check_done_o;
   logic io_in_window_o;
   logic [31:0] io_range_top_o;
   wire logic [8:0] ev;
   int fails = 0;
   int n_compared = 0;
   logic [31:0] seed;
   logic [31:0] r;
   logic [31:0] base;
   logic [31:0] m_top;
   logic [7:0] m_ev = 8'h00;
   logic [3:0] m_nib = 4'h0;
   localparam logic [7:0] EVB [9] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h01};

   always #4 core_clk_i = ~core_clk_i;

   bis_pci_agents bis_pci_agents_i (.core_clk_i(core_clk_i), .addr_attr_err_target_o(ev[0]),
      .data_err_write_target_o(ev[1]), .data_err_read_master_o(ev[2]), .serr_seen_o(ev[3]),
      .master_abort_o(ev[4]), .target_abort_rcvd_o(ev[5]), .target_abort_sent_o(ev[6]),
      .perr_driven_read_o(ev[7]), .perr_seen_write_o(ev[8]));

   bis_io_status_regs bis_io_status_regs_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i), .cfg_dw_i(cfg_dw_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
      .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .io_top_upper_i(io_top_upper_i),
      .io_window_base_i(io_window_base_i), .parity_response_enable_i(parity_response_enable_i),
      .high_speed_enable_pin_i(high_speed_enable_pin_i), .addr_attr_err_target_i(ev[0]),
      .data_err_write_target_i(ev[1]), .data_err_read_master_i(ev[2]), .serr_seen_i(ev[3]),
      .master_abort_i(ev[4]), .target_abort_rcvd_i(ev[5]), .target_abort_sent_i(ev[6]),
      .bus_master_i(bus_master_i), .perr_driven_read_i(ev[7]), .perr_seen_write_i(ev[8]),
      .io_check_i(io_check_i), .io_addr_i(io_addr_i), .io_check_done_o(io_check_done_o),
      .io_in_window_o(io_in_window_o), .io_range_top_o(io_range_top_o));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Status high byte carries the fixed 01b decode speed
   function automatic logic [31:0] exp_dw();
      return {m_ev | 8'h02, 2'h2, high_speed_enable_pin_i, 5'h00, m_nib, 4'h1, 8'h00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   task automatic wr(input logic [3:0] be, input logic [31:0] d);
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b1;
      cfg_dw_i <= 6'h07;
      cfg_be_i <= be;
      cfg_wdata_i <= d;
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b0;
      if (be[1]) m_nib = d[15:12];
      if (be[3]) m_ev = m_ev & ~(d[31:24] & 8'hF9);
   endtask

   task automatic rd(input logic [5:0] dw, input logic [31:0] exp, input string nm);
      @(posedge core_clk_i);
      cfg_rd_i <= 1'b1;
      cfg_dw_i <= dw;
      @(posedge core_clk_i);
      cfg_rd_i <= 1'b0;
      #1;
      chk("read valid", 32'h1, {31'h0, cfg_rvalid_o});
      chk(nm, exp, cfg_rdata_o);
   endtask

   task automatic win(input logic [31:0] a);
      logic [31:0] top;
      @(posedge core_clk_i);
      io_check_i <= 1'b1;
      io_addr_i <= a;
      @(posedge core_clk_i);
      io_check_i <= 1'b0;
      #1;
      top = {io_top_upper_i, m_nib, 12'hFFF};
      chk("check done", 32'h1, {31'h0, io_check_done_o});
      chk("in window", {31'h0, a >= io_window_base_i && a <= top}, {31'h0, io_in_window_o});
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      #100000;
      fails++;
      report_and_stop();
   end

   initial begin
      seed = 32'hADC7;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(6'h07, exp_dw(), "reset dword");
      rd(6'h08, 32'h0, "unmapped dword");
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         @(posedge core_clk_i);
         high_speed_enable_pin_i <= r[0];
         io_top_upper_i <= r[31:16];
         wr(4'hF, r | 32'h0000_0F00);
         rd(6'h07, exp_dw(), "top and status");
         chk("range top", {io_top_upper_i, m_nib, 12'hFFF}, io_range_top_o);
         base = {r[31:16], 4'h3, 12'h000};
         @(posedge core_clk_i);
         io_window_base_i <= base;
         m_top = {r[31:16], m_nib, 12'hFFF};
         win(base - 32'h1);
         win(base);
         win(m_top);
         win(m_top + 32'h1);
         r = rnd();
         win({io_top_upper_i, r[15:0]});
      end
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 9; i++) begin
            @(posedge core_clk_i);
            bus_master_i <= k[0];
            parity_response_enable_i <= k[1];
            bis_pci_agents_i.pulse(i);
            if (i < 7 || k == 3) m_ev = m_ev | EVB[i];
            rd(6'h07, exp_dw(), "event set");
            if (k == 3) begin
               wr(4'h7, 32'hFFFF_FFFF);
               wr(4'h8, 32'h0000_0000);
               rd(6'h07, exp_dw(), "event held");
            end
            wr(4'h8, 32'hFFFF_FFFF);
            rd(6'h07, exp_dw(), "event cleared");
         end
      end
      // System fault, then master termination, each against a same-cycle clear
      for (int i = 3; i < 5; i++) begin
         fork
            bis_pci_agents_i.pulse(i);
            wr(4'h8, 32'hFFFF_FFFF);
         join
         m_ev = m_ev | EVB[i];
         rd(6'h07, exp_dw(), "set beats clear");
      end
      report_and_stop();
   end
endmodule
